/* core/vip_top.sv */
// fixed-priority vectored interrupt controller with acceptance sequencer
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
// Operation
// - gather peripheral and gpio requests to core
// - smaller vector code wins, 00h highest
// - table address is page byte then code
// - fixed peripheral vector codes, gaps unused
// - port b, c, d pins at 30h, 40h, 50h
// - any active request raises one core request
// - winning code driven on internal vector bus
// - page and code shown on address 15:0
// - vector fetched low byte from lower address
// - acceptance reads code, clears both enables
// - mode 00: short stack, two bytes
// - mode 01: two bytes, marker 00h, set wide
// - mode 11: three bytes, marker 01h
// - low nmi pin always serviced
// - nmi beats every maskable request
// - page register resets to 00h
module vip_top
  import vip_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] periph_req,
  input  wire logic [7:0]  port_b_req,
  input  wire logic [7:0]  port_c_req,
  input  wire logic [7:0]  port_d_req,
  input  wire logic        nmi_n,
  input  wire logic        cpu_accept,
  input  wire logic [23:0] cpu_pc,
  input  wire logic [7:0]  mem_rdata,
  output logic             cpu_irq,
  output logic             cpu_nmi,
  output logic      [7:0]  vector_code_bus,
  output logic      [23:0] mem_addr,
  output logic             mem_wr,
  output logic             mem_rd,
  output logic      [7:0]  mem_wdata,
  output logic             pc_load,
  output logic      [23:0] new_pc,
  output logic             wide_address_bit,
  output logic             irq
);
  import vip_pkg::*;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] vip_first(input logic [63:0] r);
    vip_first = 6'h3f;
    for (int i = 63; i >= 0; i--) begin
      if (r[i]) begin
        vip_first = i[5:0];
      end
    end
  endfunction : vip_first

  function automatic logic vip_hit(input logic [7:0] a);
    vip_hit = (a == OFF_PAGE) || (a == OFF_MODE) || (a == OFF_SHORT_SP) ||
              (a == OFF_LONG_SP) || (a == OFF_EVT) || (a == OFF_EVT_CL) ||
              (a == OFF_EVT_EN) || (a == OFF_VECTOR) || (a == OFF_NEW_PC);
  endfunction : vip_hit

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  vip_state_e         st_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic [7:0]         page_q;
  logic [7:0]         page_base_q;
  logic               wide_q;
  logic               mixed_q;
  logic               int_en_one_q;
  logic               int_en_two_q;
  logic [15:0]        short_sp_q;
  logic [23:0]        long_sp_q;
  logic [EVT_W-1:0]   evt_q;
  logic [EVT_W-1:0]   evt_en_q;
  logic [EVT_W-1:0]   evt_set;
  logic               irq_q;
  logic               cpu_irq_q;
  logic               cpu_nmi_q;
  logic [7:0]         vec_q;
  logic [7:0]         vec_lat_q;
  logic [23:0]        mem_addr_q;
  logic               mem_wr_q;
  logic               mem_rd_q;
  logic [7:0]         mem_wdata_q;
  logic               pc_load_q;
  logic [23:0]        new_pc_q;
  logic [31:0]        pbuf_q;
  logic [2:0]         pcnt_q;
  logic               use_long_q;
  logic               mode00_q;
  logic [7:0]         lo_q;
  logic [63:0]        req_w;
  logic               take_w;
  logic               take_nmi_w;
  logic               take_mask_w;
  logic               wr_en;
  logic [23:0]        vaddr_w;

  // ---------------------------------------------------------------
  // request gathering and priority
  // ---------------------------------------------------------------
  always_comb begin
    req_w = 64'h0;
    req_w[SLOT_PERIPH +: NUM_PERIPH] = periph_req;
    req_w[SLOT_PORT_B +: 8] = port_b_req;
    req_w[SLOT_PORT_C +: 8] = port_c_req;
    req_w[SLOT_PORT_D +: 8] = port_d_req;
  end

  // registered so the core sees a clean level; costs one cycle of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_q <= 1'b0;
      cpu_nmi_q <= 1'b0;
      vec_q     <= VEC_NONE;
    end else if (clk_en) begin
      cpu_irq_q <= |req_w;
      cpu_nmi_q <= ~nmi_n;
      vec_q     <= {1'b0, vip_first(req_w), 1'b0};
    end
  end

  // sources need only hold their line until acceptance: the code
  // sampled then is latched, so it is the one serviced
  assign take_w      = clk_en && cpu_accept && st_q == ST_IDLE;
  assign take_nmi_w  = take_w && cpu_nmi_q;
  assign take_mask_w = take_w && !cpu_nmi_q && cpu_irq_q && int_en_one_q;

  // mode 00 uses the page base, others force the top byte to zero
  assign vaddr_w = mode00_q ? {page_base_q, page_q, vec_lat_q}
                            : {UPPER_ZERO, page_q, vec_lat_q};

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (clk_en) begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !vip_hit(paddr);
      prdata_q  <= 32'h0;
      if (psel && penable && !pready_q && !pwrite) begin
        case (paddr)
          OFF_PAGE:   prdata_q <= {24'h0, page_q};
          OFF_MODE:   prdata_q <= {16'h0, page_base_q, 4'h0, int_en_two_q,
                                   int_en_one_q, mixed_q, wide_q};
          OFF_SHORT_SP: prdata_q <= {16'h0, short_sp_q};
          OFF_LONG_SP:  prdata_q <= {8'h0, long_sp_q};
          OFF_EVT:    prdata_q <= {29'h0, evt_q};
          OFF_EVT_EN: prdata_q <= {29'h0, evt_en_q};
          OFF_VECTOR: prdata_q <= {22'h0, cpu_nmi_q, cpu_irq_q, vec_q};
          OFF_NEW_PC: prdata_q <= {8'h0, new_pc_q};
          default:    prdata_q <= 32'h0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // cpu context registers: sequencer wins over software writes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q       <= PAGE_RST;
      page_base_q  <= BASE_RST;
      wide_q       <= 1'b0;
      mixed_q      <= 1'b0;
      int_en_one_q <= 1'b0;
      int_en_two_q <= 1'b0;
      short_sp_q   <= SHORT_SP_RST;
      long_sp_q    <= LONG_SP_RST;
    end else if (clk_en) begin
      if (wr_en && paddr == OFF_PAGE) begin
        page_q <= pwdata[7:0];
      end
      if (wr_en && paddr == OFF_MODE) begin
        wide_q       <= pwdata[MODE_WIDE];
        mixed_q      <= pwdata[MODE_MIXED];
        int_en_one_q <= pwdata[MODE_EN_ONE];
        int_en_two_q <= pwdata[MODE_EN_TWO];
        page_base_q  <= pwdata[MODE_BASE +: 8];
      end
      if (wr_en && paddr == OFF_SHORT_SP) begin
        short_sp_q <= pwdata[15:0];
      end
      if (wr_en && paddr == OFF_LONG_SP) begin
        long_sp_q <= pwdata[23:0];
      end
      if (take_mask_w) begin
        int_en_one_q <= 1'b0;
        int_en_two_q <= 1'b0;
        if (mixed_q) begin
          wide_q <= 1'b1;
        end
      end
      if (st_q == ST_PUSH) begin
        if (use_long_q) begin
          long_sp_q <= long_sp_q - 24'h1;
        end else begin
          short_sp_q <= short_sp_q - 16'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // acceptance sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= ST_IDLE;
      pbuf_q      <= 32'h0;
      pcnt_q      <= 3'h0;
      use_long_q  <= 1'b0;
      mode00_q    <= 1'b0;
      vec_lat_q   <= 8'h0;
      lo_q        <= 8'h0;
      mem_addr_q  <= 24'h0;
      mem_wr_q    <= 1'b0;
      mem_rd_q    <= 1'b0;
      mem_wdata_q <= 8'h0;
      pc_load_q   <= 1'b0;
      new_pc_q    <= 24'h0;
    end else if (clk_en) begin
      pc_load_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          mem_wr_q <= 1'b0;
          mem_rd_q <= 1'b0;
          if (take_mask_w) begin
            vec_lat_q  <= vec_q;
            use_long_q <= wide_q || mixed_q;
            mode00_q   <= !wide_q && !mixed_q;
            st_q       <= ST_PUSH;
            case ({wide_q, mixed_q})
              2'b00: begin
                pbuf_q <= {cpu_pc[15:0], 16'h0};
                pcnt_q <= 3'd2;
              end
              2'b10: begin
                pbuf_q <= {cpu_pc, 8'h0};
                pcnt_q <= 3'd3;
              end
              2'b01: begin
                pbuf_q <= {cpu_pc[15:0], MARK_SHORT, 8'h0};
                pcnt_q <= 3'd3;
              end
              default: begin
                pbuf_q <= {cpu_pc, MARK_LONG};
                pcnt_q <= 3'd4;
              end
            endcase
          end
        end
        ST_PUSH: begin
          mem_wr_q    <= 1'b1;
          mem_wdata_q <= pbuf_q[31:24];
          mem_addr_q  <= use_long_q ? long_sp_q - 24'h1
                                    : {page_base_q, short_sp_q - 16'h1};
          pbuf_q      <= {pbuf_q[23:0], 8'h0};
          pcnt_q      <= pcnt_q - 3'h1;
          if (pcnt_q == 3'h1) begin
            st_q <= ST_FETCH_LO;
          end
        end
        ST_FETCH_LO: begin
          mem_wr_q   <= 1'b0;
          mem_rd_q   <= 1'b1;
          mem_addr_q <= vaddr_w;
          st_q       <= ST_FETCH_HI;
        end
        ST_FETCH_HI: begin
          lo_q       <= mem_rdata;
          mem_addr_q <= vaddr_w + 24'h1;
          st_q       <= ST_DONE;
        end
        ST_DONE: begin
          mem_rd_q  <= 1'b0;
          pc_load_q <= 1'b1;
          new_pc_q  <= {mode00_q ? page_base_q : UPPER_ZERO,
                        mem_rdata, lo_q};
          st_q      <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // event status, clear and enable
  // ---------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[EVT_MASK] = take_mask_w;
    evt_set[EVT_NMI]  = take_nmi_w;
    evt_set[EVT_SPUR] = take_w && !cpu_nmi_q && !take_mask_w;
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q    <= '0;
      evt_en_q <= '0;
      irq_q    <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && paddr == OFF_EVT_CL) begin
        evt_q <= (evt_q & ~pwdata[EVT_W-1:0]) | evt_set;
      end else begin
        evt_q <= evt_q | evt_set;
      end
      if (wr_en && paddr == OFF_EVT_EN) begin
        evt_en_q <= pwdata[EVT_W-1:0];
      end
      irq_q <= |(evt_q & evt_en_q);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign cpu_irq          = cpu_irq_q;
  assign cpu_nmi          = cpu_nmi_q;
  assign vector_code_bus  = vec_q;
  assign mem_addr         = mem_addr_q;
  assign mem_wr           = mem_wr_q;
  assign mem_rd           = mem_rd_q;
  assign mem_wdata        = mem_wdata_q;
  assign pc_load          = pc_load_q;
  assign new_pc           = new_pc_q;
  assign wide_address_bit = wide_q;
  assign irq              = irq_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  irq_raise_a: assert property (|req_w |=> cpu_irq_q)
    else $error("core request missing");
  irq_drop_a: assert property (!(|req_w) |=> !cpu_irq_q)
    else $error("core request stuck high");
  flash_prio_a: assert property (req_w[SLOT_FLASH] |=>
    vec_q == VEC_FLASH) else $error("flash code wrong");
  port_b_a: assert property (req_w[SLOT_PORT_B] &&
    !(|req_w[SLOT_PORT_B-1:0]) |=> vec_q == VEC_PORT_B)
    else $error("port b code wrong");
  ief_clear_a: assert property (take_mask_w |=>
    !int_en_one_q && !int_en_two_q ##3 st_q != ST_IDLE)
    else $error("enable flags not cleared");
  nmi_first_a: assert property (take_nmi_w |=>
    st_q == ST_IDLE && evt_q[EVT_NMI])
    else $error("nmi did not take precedence");
  short_push_a: assert property (take_mask_w && !wide_q && !mixed_q
    |=> ##1 mem_wr_q [*2] ##1 !mem_wr_q)
    else $error("short push count wrong");
  long_mark_a: assert property (take_mask_w && wide_q && mixed_q
    |=> ##4 mem_wr_q && mem_wdata_q == MARK_LONG)
    else $error("long marker wrong");
  mixed_wide_a: assert property (take_mask_w && mixed_q && !wide_q
    |=> wide_q)
    else $error("wide bit not set");
  vec_addr_a: assert property (st_q == ST_FETCH_HI |->
    mem_rd_q && mem_addr_q[15:0] == {page_q, vec_lat_q})
    else $error("vector address wrong");
  upper_zero_a: assert property (pc_load_q && !mode00_q |->
    new_pc_q[23:16] == UPPER_ZERO) else $error("upper pc not zero");
  mask_cov_c: cover property (take_mask_w ##[1:12] pc_load_q);
  nmi_cov_c:  cover property (take_nmi_w);
  both_cov_c: cover property (cpu_nmi_q && cpu_irq_q && take_w);
endmodule : vip_top

/* core/vip_pkg.sv */
// constants for the vectored interrupt priority controller
package vip_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses on apb)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PAGE   = 8'h00;
  localparam logic [7:0] OFF_MODE   = 8'h04;
  localparam logic [7:0] OFF_SHORT_SP = 8'h08;
  localparam logic [7:0] OFF_LONG_SP  = 8'h0c;
  localparam logic [7:0] OFF_EVT    = 8'h10;
  localparam logic [7:0] OFF_EVT_CL = 8'h14;
  localparam logic [7:0] OFF_EVT_EN = 8'h18;
  localparam logic [7:0] OFF_VECTOR = 8'h1c;
  localparam logic [7:0] OFF_NEW_PC = 8'h20;
  // ---------------------------------------------------------------
  // mode register fields
  // ---------------------------------------------------------------
  localparam int MODE_WIDE  = 0;
  localparam int MODE_MIXED = 1;
  localparam int MODE_EN_ONE = 2;
  localparam int MODE_EN_TWO = 3;
  localparam int MODE_BASE  = 8;
  localparam logic [7:0]  PAGE_RST = 8'h00;
  localparam logic [7:0]  BASE_RST = 8'h00;
  localparam logic [15:0] SHORT_SP_RST = 16'h0000;
  localparam logic [23:0] LONG_SP_RST  = 24'h000000;
  // ---------------------------------------------------------------
  // event bits
  // ---------------------------------------------------------------
  localparam int EVT_W     = 3;
  localparam int EVT_MASK  = 0;
  localparam int EVT_NMI   = 1;
  localparam int EVT_SPUR  = 2;
  // ---------------------------------------------------------------
  // request map: slot index = vector code / 2
  // ---------------------------------------------------------------
  localparam int SLOT_FLASH  = 4;
  localparam int SLOT_PERIPH = 4;
  localparam int NUM_PERIPH  = 12;
  localparam int SLOT_PORT_B = 24;
  localparam int SLOT_PORT_C = 32;
  localparam int SLOT_PORT_D = 40;
  localparam logic [7:0] VEC_FLASH  = 8'h08;
  localparam logic [7:0] VEC_PORT_B = 8'h30;
  localparam logic [7:0] VEC_NONE   = 8'h7e;
  // ---------------------------------------------------------------
  // stack markers, upper pc byte and sequencer states
  // ---------------------------------------------------------------
  localparam logic [7:0] MARK_SHORT = 8'h00;
  localparam logic [7:0] MARK_LONG  = 8'h01;
  localparam logic [7:0] UPPER_ZERO = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_PUSH     = 3'b001,
    ST_FETCH_LO = 3'b010,
    ST_FETCH_HI = 3'b011,
    ST_DONE     = 3'b100
  } vip_state_e;
endpackage : vip_pkg

/* tb/vip_core_model.sv */
// processor core model: accept strobe and vector table memory
`timescale 1ns/1ps
module vip_core_model (
  input  wire logic        pclk,
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             cpu_accept,
  output logic      [23:0] cpu_pc
);
  logic [7:0]  last_q = 8'h00;
  logic [31:0] wr_log[$];
  logic [23:0] rd_log[$];
  // --------
  // vector memory
  // --------
  // byte mixes both address bytes so a wrong page gives a wrong pc
  function automatic logic [7:0] tbl(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : tbl
  // idle bus shows the inverse, never a stale byte that could pass
  assign mem_rdata = mem_rd ? tbl(mem_addr) : ~last_q;
  always @(posedge pclk) begin
    if (mem_rd) begin
      last_q <= tbl(mem_addr);
      rd_log.push_back(mem_addr);
    end
    if (mem_wr) begin
      wr_log.push_back({mem_addr, mem_wdata});
    end
  end
  // --------
  // acceptance strobe
  // --------
  initial begin
    cpu_accept = 1'b0;
    cpu_pc     = 24'h000000;
  end
  task automatic accept(input logic [23:0] pc);
    @(posedge pclk);
    cpu_accept <= 1'b1;
    cpu_pc     <= pc;
    @(posedge pclk);
    cpu_accept <= 1'b0;
    cpu_pc     <= ~pc;
  endtask : accept
endmodule : vip_core_model

/* tb/test_vectored_interrupt_priority.sv */
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module test_vectored_interrupt_priority;
  import vip_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, nmi_n, err;
  logic [7:0]  paddr, mem_rdata, mem_wdata, vector_code_bus, code, base;
  logic [31:0] pwdata, prdata, rd, exp_q[$];
  logic        pready, pslverr, cpu_accept, cpu_irq, cpu_nmi;
  logic        mem_wr, mem_rd, pc_load, wide_address_bit, irq;
  logic [23:0] cpu_pc, mem_addr, new_pc, a;
  logic [35:0] req;
  logic        wide, mixed;
  int          failures = 0;
  int          comparisons = 0;
  int          pa[4] = '{35, 20, 19, 2};
  int          pb[4] = '{0, 12, 11, 1};
  always #2.5 pclk = ~pclk;
  vip_top vip_top_i (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .periph_req(req[11:0]),
    .port_b_req(req[19:12]), .port_c_req(req[27:20]),
    .port_d_req(req[35:28]), .nmi_n, .cpu_accept, .cpu_pc, .mem_rdata,
    .cpu_irq, .cpu_nmi, .vector_code_bus, .mem_addr, .mem_wr, .mem_rd,
    .mem_wdata, .pc_load, .new_pc, .wide_address_bit, .irq
  );
  vip_core_model vip_core_model_i (
    .pclk, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata,
    .cpu_accept, .cpu_pc
  );
  // --------
  // tasks
  // --------
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // one apb transfer; answer waited for under a bound
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      test_done();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_load();
    int n;
    n = 0;
    while (pc_load !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 40) begin
        failures++;
        test_done();
      end
    end
  endtask : wait_load
  function automatic logic [7:0] code_of(input int i);
    if (i < 12) return 8'(8 + 2 * i);
    return 8'(8'h30 + 16 * ((i - 12) / 8) + 2 * ((i - 12) % 8));
  endfunction : code_of
  // --------
  // main sequence
  // --------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    nmi_n   = 1'b1;
    req     = 36'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_PAGE, 32'h0);
    chk("page reset", 32'h0, rd);
    chk("idle vector", 8'h7e, vector_code_bus);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 1, err);
    // every source alone, then released
    for (int i = 0; i < 36; i++) begin
      req <= 36'h1 << i;
      cyc(2);
      chk("vector", code_of(i), vector_code_bus);
      chk("core req", 1, cpu_irq);
      req <= 36'h0;
      cyc(2);
      chk("req drop", 0, cpu_irq);
    end
    // pairs: smaller code must win, read back through the register
    for (int i = 0; i < 4; i++) begin
      req <= (36'h1 << pa[i]) | (36'h1 << pb[i]);
      apb(1'b0, OFF_VECTOR, 32'h0);
      chk("pair", {1'b1, code_of(pb[i])}, rd[8:0]);
    end
    // acceptance in all four memory modes
    code = code_of(7);
    for (int m = 0; m < 4; m++) begin
      wide  = m[0];
      mixed = m[1];
      base  = (m == 0) ? 8'h3c : 8'h00;
      apb(1'b1, OFF_EVT_CL, 32'h7);
      apb(1'b1, OFF_PAGE, 32'ha4);
      apb(1'b1, OFF_MODE, {16'h0, 8'h3c, 4'h0, 2'b11, mixed, wide});
      apb(1'b1, OFF_SHORT_SP, 32'h8000);
      apb(1'b1, OFF_LONG_SP, 32'h409000);
      req <= 36'h80;
      cyc(2);
      vip_core_model_i.wr_log.delete();
      vip_core_model_i.rd_log.delete();
      vip_core_model_i.accept(24'h123456);
      wait_load();
      a = {base, 8'ha4, code};
      chk("new pc", {base, (code + 8'h1) ^ 8'hfe, code ^ 8'hfe},
          new_pc);
      chk("vector addr", a, vip_core_model_i.rd_log[0]);
      req <= 36'h0;
      exp_q.delete();
      if (m == 0) begin
        exp_q = '{{8'h3c, 16'h7fff, 8'h34}, {8'h3c, 16'h7ffe, 8'h56}};
      end else begin
        if (wide) exp_q.push_back(32'h12);
        exp_q.push_back(32'h34);
        exp_q.push_back(32'h56);
        if (mixed) exp_q.push_back({31'h0, wide});
        foreach (exp_q[k]) exp_q[k] = {24'h409000 - 24'(k + 1), exp_q[k][7:0]};
      end
      chk("push count", exp_q.size(), vip_core_model_i.wr_log.size());
      foreach (exp_q[k]) begin
        chk("push", exp_q[k], vip_core_model_i.wr_log[k]);
      end
      chk("wide bit", wide | mixed, wide_address_bit);
      apb(1'b0, OFF_MODE, 32'h0);
      chk("mode", {8'h3c, 6'h0, mixed, wide | mixed}, rd);
    end
    // event raised, masked, cleared
    apb(1'b0, OFF_EVT, 32'h0);
    chk("event", 1, rd);
    chk("irq masked", 0, irq);
    apb(1'b1, OFF_EVT_EN, 32'h1);
    cyc(2);
    chk("irq on", 1, irq);
    apb(1'b1, OFF_EVT_EN, 32'h0);
    cyc(2);
    chk("irq mask", 0, irq);
    apb(1'b1, OFF_EVT_EN, 32'h1);
    apb(1'b1, OFF_EVT_CL, 32'h7);
    cyc(2);
    chk("irq clear", 0, irq);
    // nmi with enables cleared and a maskable line pending
    nmi_n <= 1'b0;
    req   <= 36'h1;
    cyc(2);
    chk("nmi req", 1, cpu_nmi);
    vip_core_model_i.wr_log.delete();
    vip_core_model_i.accept(24'h0000aa);
    cyc(10);
    chk("nmi pushes", 0, vip_core_model_i.wr_log.size());
    apb(1'b0, OFF_EVT, 32'h0);
    chk("nmi event", 2, rd);
    nmi_n <= 1'b1;
    req   <= 36'h0;
    cyc(2);
    test_done();
  end
endmodule : test_vectored_interrupt_priority
